/* File: hdl/slf_pkg.sv */
// Package for the loop filter and second synthesizer control register bank
package slf_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] OFF_CAP_ONE = 8'h44;
    localparam logic [7:0] OFF_RES_THREE = 8'h45;
    localparam logic [7:0] OFF_CAP_THREE = 8'h46;
    localparam logic [7:0] OFF_CTRL_ZERO = 8'h47;
    localparam int CAP_LSB = 0;
    localparam int CAP_W = 3;
    localparam int RES_LSB = 0;
    localparam int RES_W = 7;
    localparam int PDIV_LSB = 2;
    localparam int PDIV_W = 3;
    localparam int SYNC_BIT = 1;
    localparam int PDN_BIT = 0;
    localparam logic [2:0] CAP_ONE_RST = 3'h0;
    localparam logic [2:0] CAP_THREE_RST = 3'h0;
    localparam logic [6:0] RES_THREE_RST = 7'h00;
    localparam logic [2:0] PDIV_RST = 3'h7;
    localparam logic SYNC_RST = 1'b1;
    localparam logic PDN_RST = 1'b0;
    localparam logic [8:0] CAP_ONE_BASE_PF = 9'h005;
    localparam logic [8:0] CAP_ONE_STEP_PF = 9'h032;
    localparam logic [5:0] CAP_THREE_STEP_PF = 6'h05;
    localparam logic [3:0] PDIV_MIN_RATIO = 4'h2;
    // Cycles the calibration runs after power-up or release of power-down
    localparam int CAL_TIME_NS = 1000;
    localparam int CLK_PERIOD_NS = 20;
    localparam int CAL_CYCLES = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } slf_bus_s;

    typedef struct packed {
        logic [CAP_W-1:0] cap_one_code;
        logic [RES_W-1:0] res_three_code;
        logic [CAP_W-1:0] cap_three_code;
        logic [8:0] cap_one_pf;
        logic [5:0] cap_three_pf;
    } slf_filter_s;

    typedef struct packed {
        logic [PDIV_W-1:0] post_divider;
        logic [3:0] post_ratio;
        logic enable;
        logic cal_reset;
        logic cal_start;
        logic calibrating;
        logic resync;
    } slf_synth2_s;
endpackage

/* File: hdl/slf_regs.sv */
// Loop filter and second synthesizer control register bank
// Operation
// R1 - Filter cap one is a 3-bit RW code at bits 2:0, reset 0, worth 5 + 50*code pF.
// R2 - Filter cap three is a 3-bit RW code at bits 2:0, reset 0, worth 5*code pF.
// R3 - Filter res three is a 7-bit RW code at bits 6:0, reset 0x00, bit 7 reserved.
// R4 - Every res three code is a valid selection and is passed to the filter unchanged.
// R5 - Post divider at bits 4:2 resets to 7; codes 0 and 1 divide by 2, others by code+1.
// R6 - Resync enable at bit 1 resets to 1 and lets a sync event realign the channels.
// R7 - Power down at bit 0 resets to 0, so the synthesizer starts and calibrates after reset.
// R8 - Setting power down disables the synthesizer and holds calibration in reset.
// R9 - Clearing power down re-enables the synthesizer and starts calibration by itself.
// R10 - Reserved bits read zero and drop writes; defined fields load from nonvolatile storage.
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
module slf_regs
    import slf_pkg::*;
#(
    parameter int CAL_LEN = CAL_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire slf_bus_s bus,
    output logic [DATA_W-1:0] rdata,
    input wire logic nv_load,
    input wire logic [31:0] nv_image,
    input wire logic sync_event,
    output slf_filter_s filter,
    output slf_synth2_s synth2
);
    typedef enum logic [1:0] {SLF_OFF, SLF_CAL, SLF_RUN} slf_state_e;

    logic [CAP_W-1:0] cap_one_q;
    logic [CAP_W-1:0] cap_three_q;
    logic [RES_W-1:0] res_three_q;
    logic [PDIV_W-1:0] pdiv_q;
    logic sync_en_q;
    logic pdn_q;
    logic [DATA_W-1:0] rdata_q;
    slf_filter_s filter_q;
    slf_filter_s filter_d;
    slf_synth2_s synth2_q;
    slf_synth2_s synth2_d;
    slf_state_e state_q, state_d;
    logic [15:0] cal_cnt_q, cal_cnt_d;
    logic sync_m_q, sync_s_q, sync_prev_q;

    // Address decode
    wire hit_c1 = bus.addr == OFF_CAP_ONE;
    wire hit_r3 = bus.addr == OFF_RES_THREE;
    wire hit_c3 = bus.addr == OFF_CAP_THREE;
    wire hit_ct = bus.addr == OFF_CTRL_ZERO;
    wire [DATA_W-1:0] ctrl_rd = {3'h0, pdiv_q, sync_en_q, pdn_q};
    // Unmapped addresses and reserved bits read as zero
    wire [DATA_W-1:0] rd_mux = hit_c1 ? {5'h00, cap_one_q} : // R10
                               hit_r3 ? {1'b0, res_three_q} : // R3
                               hit_c3 ? {5'h00, cap_three_q} :
                               hit_ct ? ctrl_rd : 8'h00;

    // Nonvolatile image byte lanes mirror the register order, reserved bits skipped
    wire [7:0] nv_c1 = nv_image[7:0];
    wire [7:0] nv_r3 = nv_image[15:8];
    wire [7:0] nv_c3 = nv_image[23:16];
    wire [7:0] nv_ct = nv_image[31:24];

    // Write enables; a nonvolatile load beats a bus write in the same cycle
    wire bus_wr = bus.wr & ~nv_load;
    wire ld_c1 = nv_load | (bus_wr & hit_c1); // R10
    wire ld_r3 = nv_load | (bus_wr & hit_r3);
    wire ld_c3 = nv_load | (bus_wr & hit_c3);
    wire ld_ct = nv_load | (bus_wr & hit_ct);

    // Next values keep only defined field bits, so reserved bits are never stored
    wire [CAP_W-1:0] cap_one_d = nv_load ? nv_c1[CAP_LSB +: CAP_W] :
                                           bus.wdata[CAP_LSB +: CAP_W]; // R1
    wire [RES_W-1:0] res_three_d = nv_load ? nv_r3[RES_LSB +: RES_W] :
                                             bus.wdata[RES_LSB +: RES_W]; // R4
    wire [CAP_W-1:0] cap_three_d = nv_load ? nv_c3[CAP_LSB +: CAP_W] :
                                             bus.wdata[CAP_LSB +: CAP_W]; // R2
    wire [PDIV_W-1:0] pdiv_d = nv_load ? nv_ct[PDIV_LSB +: PDIV_W] :
                                         bus.wdata[PDIV_LSB +: PDIV_W]; // R5
    wire sync_en_d = nv_load ? nv_ct[SYNC_BIT] : bus.wdata[SYNC_BIT]; // R6
    wire pdn_d = nv_load ? nv_ct[PDN_BIT] : bus.wdata[PDN_BIT]; // R8

    // Derived analog settings
    wire [8:0] c1_pf = CAP_ONE_BASE_PF + 9'(CAP_ONE_STEP_PF * 9'(cap_one_q)); // R1
    wire [5:0] c3_pf = 6'(CAP_THREE_STEP_PF * 6'(cap_three_q)); // R2
    wire [3:0] p_ratio = (pdiv_q < 3'h2) ? PDIV_MIN_RATIO : 4'(pdiv_q) + 4'h1; // R5

    // Sync event is asynchronous, so it is synchronised before the edge detect
    wire sync_rise = sync_s_q & ~sync_prev_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cap_one_q <= CAP_ONE_RST; // R1
        end else if (ld_c1) begin
            cap_one_q <= cap_one_d;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            res_three_q <= RES_THREE_RST; // R3
        end else if (ld_r3) begin
            res_three_q <= res_three_d; // R4
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cap_three_q <= CAP_THREE_RST; // R2
        end else if (ld_c3) begin
            cap_three_q <= cap_three_d;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pdiv_q <= PDIV_RST; // R5
        end else if (ld_ct) begin
            pdiv_q <= pdiv_d;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync_en_q <= SYNC_RST; // R6
        end else if (ld_ct) begin
            sync_en_q <= sync_en_d;
        end
    end

    // Power down is taken at once; the sequencer below reacts on the next edge
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pdn_q <= PDN_RST; // R7
        end else if (ld_ct) begin
            pdn_q <= pdn_d; // R8
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= bus.rd ? rd_mux : 8'h00;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync_m_q <= 1'b0;
            sync_s_q <= 1'b0;
            sync_prev_q <= 1'b0;
        end else begin
            sync_m_q <= sync_event;
            sync_s_q <= sync_m_q;
            sync_prev_q <= sync_s_q;
        end
    end

    // Calibration sequencer; leaves reset through SLF_CAL so a power-up calibrates too
    always_comb begin
        state_d = state_q;
        cal_cnt_d = cal_cnt_q;
        case (state_q)
            SLF_OFF: begin
                if (!pdn_q) begin
                    state_d = SLF_CAL; // R9
                    cal_cnt_d = 16'(CAL_LEN - 1);
                end
            end
            SLF_CAL: begin
                if (pdn_q) begin
                    state_d = SLF_OFF; // R8
                end else if (cal_cnt_q == 16'h0000) begin
                    state_d = SLF_RUN;
                end else begin
                    cal_cnt_d = cal_cnt_q - 16'h0001;
                end
            end
            SLF_RUN: begin
                if (pdn_q) begin
                    state_d = SLF_OFF; // R8
                end
            end
            default: begin
                state_d = SLF_OFF;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= SLF_OFF;
            cal_cnt_q <= 16'h0000;
        end else begin
            state_q <= state_d;
            cal_cnt_q <= cal_cnt_d;
        end
    end

    // Output images, gathered before the output flops
    assign filter_d = '{
        cap_one_code: cap_one_q,
        res_three_code: res_three_q, // R4
        cap_three_code: cap_three_q,
        cap_one_pf: c1_pf, // R1
        cap_three_pf: c3_pf // R2
    };
    assign synth2_d = '{
        post_divider: pdiv_q,
        post_ratio: p_ratio, // R5
        enable: ~pdn_q, // R7
        cal_reset: pdn_q, // R8
        cal_start: (state_q == SLF_OFF) && (state_d == SLF_CAL), // R9
        calibrating: state_d == SLF_CAL,
        resync: sync_rise & sync_en_q // R6
    };

    // Outputs are registered so downstream analog controls never see decode glitches
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            filter_q <= '0;
        end else begin
            filter_q <= filter_d;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            synth2_q <= '0;
        end else begin
            synth2_q <= synth2_d;
        end
    end

    assign rdata = rdata_q;
    assign filter = filter_q;
    assign synth2 = synth2_q;
endmodule // slf_regs

/* File: verif/slf_regs_props.sv */
// Port assertions for the loop filter and control register bank
`timescale 1ns/1ps
module slf_regs_props
    import slf_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire slf_bus_s bus,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic nv_load,
    input wire logic [31:0] nv_image,
    input wire logic sync_event,
    input wire slf_filter_s filter,
    input wire slf_synth2_s synth2
);
    logic sync_q;
    // Decodes are only meaningful once the outputs left their all-zero reset state
    wire live = synth2.enable | synth2.cal_reset;
    wire wr_ctl = bus.wr & (bus.addr == OFF_CTRL_ZERO) & ~nv_load;
    wire wr_res = bus.wr & (bus.addr == OFF_RES_THREE) & ~nv_load;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) sync_q <= SYNC_RST;
        else if (nv_load) sync_q <= nv_image[24+SYNC_BIT];
        else if (wr_ctl) sync_q <= bus.wdata[SYNC_BIT];
    end
    sequence s_pdn_off; !synth2.enable && synth2.cal_reset && !synth2.calibrating; endsequence
    sequence s_cal_go; synth2.cal_start && synth2.enable; endsequence
    a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 8'h00)
        else $error("read data outside a read");
    a_res_pass: assert property (wr_res |-> ##2 filter.res_three_code == $past(bus.wdata[6:0], 2))
        else $error("res three code lost");
    a_pdn_set: assert property (wr_ctl && bus.wdata[PDN_BIT] |-> ##2 s_pdn_off)
        else $error("power down ignored");
    a_pdn_clear: assert property ($fell(synth2.cal_reset) |-> ##[0:2] s_cal_go)
        else $error("no restart after power down");
    a_cal_end: assert property ($rose(synth2.cal_start) |-> ##[1:12] !synth2.calibrating)
        else $error("calibration never ends");
    a_ratio_map: assert property (live |-> synth2.post_ratio ==
        ((synth2.post_divider < 3'h2) ? 4'h2 : {1'b0, synth2.post_divider} + 4'h1))
        else $error("post ratio wrong");
    a_cap_pf: assert property (live |->
        filter.cap_one_pf == 9'h005 + 9'h032 * filter.cap_one_code
        && filter.cap_three_pf == 6'h05 * filter.cap_three_code) else $error("cap pF");
    a_resync_gate: assert property (synth2.resync |-> sync_q && !$past(synth2.resync))
        else $error("resync while disabled");
endmodule // slf_regs_props

/* File: verif/slf_regs_tb.sv */
// Self-checking bench for the loop filter and control register bank
`timescale 1ns/1ps
module slf_regs_tb;
    import slf_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    slf_bus_s bus = '0;
    logic sync_event = 1'b0;
    logic nv_load = 1'b0;
    logic [31:0] nv_image = 32'h0;
    // Short calibration keeps the run brief; the checks are reckoned from it
    localparam int TB_CAL = 4;
    logic [DATA_W-1:0] rdata;
    slf_filter_s filter;
    slf_synth2_s synth2;
    int fails = 0;
    int num_checks = 0;
    int i;
    always #10 clk = ~clk;
    slf_regs #(.CAL_LEN(TB_CAL)) i_slf_regs(.clk(clk), .rstn(rstn), .bus(bus), .rdata(rdata),
        .nv_load(nv_load), .nv_image(nv_image), .sync_event(sync_event), .filter(filter),
        .synth2(synth2));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 chk("rdata", {8'h00, exp}, {8'h00, rdata});
    endtask
    task automatic t_fields;
        for (i = 0; i < 5; i++) wr(OFF_CAP_ONE + i[7:0], 8'hFF);
        rd(OFF_CAP_ONE, 8'h07);
        rd(OFF_RES_THREE, 8'h7F);
        rd(OFF_CAP_THREE, 8'h07);
        rd(OFF_CTRL_ZERO, 8'h1F);
        rd(8'h48, 8'h00);
        chk("cap_one_pf", 16'h0163, {7'h0, filter.cap_one_pf});
        chk("cap_three_pf", 16'h0023, {10'h0, filter.cap_three_pf});
        for (i = 0; i < 8; i++) begin
            wr(OFF_RES_THREE, 8'h01 << i);
            chk("res_code", 16'(8'h7F & (8'h01 << i)), {9'h0, filter.res_three_code});
        end
    endtask
    task automatic t_div;
        for (i = 0; i < 8; i++) begin
            wr(OFF_CTRL_ZERO, {3'h0, i[2:0], 2'h2});
            chk("post_ratio", (i < 2) ? 16'h2 : 16'(i + 1), {12'h0, synth2.post_ratio});
        end
    endtask
    task automatic t_pdn;
        wr(OFF_CTRL_ZERO, 8'h03);
        chk("enable", 16'h0, {15'h0, synth2.enable});
        chk("cal_reset", 16'h1, {15'h0, synth2.cal_reset});
        @(posedge clk);
        bus <= '{addr: OFF_CTRL_ZERO, wdata: 8'h02, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
        for (i = 0; i < 6 && synth2.cal_start !== 1'b1; i++) @(negedge clk);
        chk("cal_start", 16'h1, {15'h0, synth2.cal_start});
        chk("enable", 16'h1, {15'h0, synth2.enable});
        @(negedge clk);
        chk("cal_start", 16'h0, {15'h0, synth2.cal_start});
        chk("calibrating", 16'h1, {15'h0, synth2.calibrating});
        repeat (TB_CAL - 2) @(negedge clk);
        chk("calibrating", 16'h1, {15'h0, synth2.calibrating});
        @(negedge clk);
        chk("calibrating", 16'h0, {15'h0, synth2.calibrating});
    endtask
    task automatic t_nvload;
        @(posedge clk);
        nv_image <= 32'hE9FA_A5FD;
        nv_load <= 1'b1;
        bus <= '{addr: OFF_CAP_ONE, wdata: 8'h03, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        nv_load <= 1'b0;
        bus.wr <= 1'b0;
        rd(OFF_CAP_ONE, 8'h05);
        rd(OFF_RES_THREE, 8'h25);
        rd(OFF_CAP_THREE, 8'h02);
        rd(OFF_CTRL_ZERO, 8'h09);
        chk("cap_one_code", 16'h0005, {13'h0, filter.cap_one_code});
        chk("cap_three_code", 16'h0002, {13'h0, filter.cap_three_code});
        chk("post_divider", 16'h0002, {13'h0, synth2.post_divider});
        chk("enable", 16'h0000, {15'h0, synth2.enable});
    endtask
    task automatic t_sync(input logic en);
        wr(OFF_CTRL_ZERO, {6'h07, en, 1'b0});
        @(posedge clk);
        sync_event <= 1'b1;
        i = 0;
        repeat (10) begin
            @(negedge clk);
            if (synth2.resync === 1'b1) i++;
        end
        @(posedge clk);
        sync_event <= 1'b0;
        chk("resync_count", {15'h0, en}, i[15:0]);
    endtask
    task automatic end_of_test;
        if (fails == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        rd(OFF_CAP_ONE, 8'h00);
        rd(OFF_RES_THREE, 8'h00);
        rd(OFF_CAP_THREE, 8'h00);
        rd(OFF_CTRL_ZERO, 8'h1E);
        chk("enable", 16'h1, {15'h0, synth2.enable});
        t_fields;
        t_div;
        t_pdn;
        t_sync(1'b0);
        t_sync(1'b1);
        t_nvload;
        end_of_test;
    end
    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        end_of_test;
    end
endmodule // slf_regs_tb
bind slf_regs slf_regs_props i_slf_regs_props(.clk(clk), .rstn(rstn), .bus(bus), .rdata(rdata),
    .nv_load(nv_load), .nv_image(nv_image), .sync_event(sync_event), .filter(filter),
    .synth2(synth2));
